//--- design/pin_function_arbiter.sv
// Operation
// RULE_01 - After reset every analog-capable pin starts in analog mode.
// RULE_02 - Analog pin: digital input buffer off, pin and latch reads return 0.
// RULE_03 - Clearing a pin's analog select bit makes it digital.
// RULE_04 - Output direction still drives the pin while analog is selected.
// RULE_05 - Fixed priority: higher enabled function blocks all lower ones on a pin; code ranks pin_owner, out_val; analog pins still drive, remap still reads
// RULE_06 - Each pin has separately enabled weak pull-up and pull-down.
// RULE_07 - At most one output function drives a pin at a time.
// RULE_08 - One remappable output may be routed to several pins together.
// RULE_09 - Dedicated output beats any remappable output on the same pin.
// RULE_10 - Remappable inputs still read a pin owned by a dedicated function.
// RULE_11 - Dedicated analog disables digital inputs but allows one driven output.
// RULE_12 - Many remappable inputs may sample the same pin, even an output pin.
// RULE_13 - Pin controls derive from registered config, effective the edge after a write.
`timescale 1ns/1ps
module pin_function_arbiter #(
   parameter int NUM_PINS = pin_function_pkg::NUM_PINS,
   parameter int NUM_REMAP_OUT = pin_function_pkg::NUM_REMAP_OUT,
   parameter int NUM_REMAP_IN = pin_function_pkg::NUM_REMAP_IN
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   // Configuration writes, one strobe per register, full word
   input wire logic analog_select_we,
   input wire logic [NUM_PINS-1:0] analog_select_wdata,
   input wire logic direction_we,
   input wire logic [NUM_PINS-1:0] direction_wdata,
   input wire logic output_latch_we,
   input wire logic [NUM_PINS-1:0] output_latch_wdata,
   input wire logic pullup_enable_we,
   input wire logic [NUM_PINS-1:0] pullup_enable_wdata,
   input wire logic pulldown_enable_we,
   input wire logic [NUM_PINS-1:0] pulldown_enable_wdata,
   // Remap selector write: one pin's output selector
   input wire logic remap_selector_we,
   input wire logic [pin_function_pkg::PIN_IDX_W-1:0] remap_selector_pin,
   input wire logic [pin_function_pkg::SEL_W-1:0] remap_selector_wdata,
   // Remappable input source selection, one pin index per input function
   input wire logic remap_input_we,
   input wire logic [1:0] remap_input_func,
   input wire logic [pin_function_pkg::PIN_IDX_W-1:0] remap_input_wdata,
   // Dedicated peripheral functions per pin
   input wire logic [NUM_PINS-1:0] ded_analog_en,
   input wire logic [NUM_PINS-1:0] ded_out_en,
   input wire logic [NUM_PINS-1:0] ded_out_val,
   input wire logic [NUM_PINS-1:0] ded_in_en,
   // Remappable peripheral outputs
   input wire logic [NUM_REMAP_OUT-1:0] remap_out_val,
   // Package pins
   input wire logic [NUM_PINS-1:0] pin_in,
   output logic [NUM_PINS-1:0] pin_out,
   output logic [NUM_PINS-1:0] pin_oe,
   output logic [NUM_PINS-1:0] pin_pullup_en,
   output logic [NUM_PINS-1:0] pin_pulldown_en,
   // Read-back and peripheral inputs
   output logic [NUM_PINS-1:0] pin_level_reg,
   output logic [NUM_PINS-1:0] output_latch_rd,
   output logic [NUM_PINS-1:0] analog_select_rd,
   output logic [NUM_PINS-1:0] ded_in_val,
   output logic [NUM_REMAP_IN-1:0] remap_in_val,
   output logic [3*NUM_PINS-1:0] pin_owner
);
   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic [NUM_PINS-1:0] analog_select_reg;
   logic [NUM_PINS-1:0] direction_reg;
   logic [NUM_PINS-1:0] output_latch_reg;
   logic [NUM_PINS-1:0] pullup_enable_reg;
   logic [NUM_PINS-1:0] pulldown_enable_reg;
   logic [pin_function_pkg::SEL_W-1:0] remap_selector [NUM_PINS];
   logic [pin_function_pkg::PIN_IDX_W-1:0] remap_input_src [NUM_REMAP_IN];

   // Write strobes count only while the clock enable is high
   logic analog_select_load;
   logic direction_load;
   logic output_latch_load;
   logic pullup_enable_load;
   logic pulldown_enable_load;
   logic remap_selector_load;
   logic remap_input_load;
   assign analog_select_load = clk_en & analog_select_we;
   assign direction_load = clk_en & direction_we;
   assign output_latch_load = clk_en & output_latch_we;
   assign pullup_enable_load = clk_en & pullup_enable_we;
   assign pulldown_enable_load = clk_en & pulldown_enable_we;
   assign remap_selector_load = clk_en & remap_selector_we;
   assign remap_input_load = clk_en & remap_input_we;

   // Analog select, all analog out of reset
   always_ff @(posedge clk) begin
      if (reset) begin
         analog_select_reg <= {NUM_PINS{pin_function_pkg::RST_ANALOG}}; // see RULE_01
      end else if (analog_select_load) begin
         analog_select_reg <= analog_select_wdata; // see RULE_03
      end
   end

   // Direction, all inputs out of reset
   always_ff @(posedge clk) begin
      if (reset) begin
         direction_reg <= {NUM_PINS{pin_function_pkg::RST_DIR_INPUT}};
      end else if (direction_load) begin
         direction_reg <= direction_wdata;
      end
   end

   // Output latch
   always_ff @(posedge clk) begin
      if (reset) begin
         output_latch_reg <= {NUM_PINS{pin_function_pkg::RST_LATCH}};
      end else if (output_latch_load) begin
         output_latch_reg <= output_latch_wdata;
      end
   end

   // Weak pull-up enables
   always_ff @(posedge clk) begin
      if (reset) begin
         pullup_enable_reg <= {NUM_PINS{pin_function_pkg::RST_PULL}};
      end else if (pullup_enable_load) begin
         pullup_enable_reg <= pullup_enable_wdata; // see RULE_06
      end
   end

   // Weak pull-down enables
   always_ff @(posedge clk) begin
      if (reset) begin
         pulldown_enable_reg <= {NUM_PINS{pin_function_pkg::RST_PULL}};
      end else if (pulldown_enable_load) begin
         pulldown_enable_reg <= pulldown_enable_wdata; // see RULE_06
      end
   end

   // Remappable output selectors, none out of reset
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            remap_selector[i] <= pin_function_pkg::REMAP_NONE;
         end
      end else if (remap_selector_load) begin
         remap_selector[remap_selector_pin] <= remap_selector_wdata; // see RULE_08
      end
   end

   // Remappable input sources
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int j = 0; j < NUM_REMAP_IN; j++) begin
            remap_input_src[j] <= '0;
         end
      end else if (remap_input_load) begin
         remap_input_src[remap_input_func] <= remap_input_wdata; // see RULE_12
      end
   end

   // ---------------------------------------------------------------
   // Per-pin arbitration
   // ---------------------------------------------------------------
   localparam int OWNER_W = $bits(pin_function_pkg::owner_t);
   logic [NUM_PINS-1:0] is_analog;
   logic [NUM_PINS-1:0] next_pin_out;
   logic [NUM_PINS-1:0] next_pin_oe;
   logic [NUM_PINS-1:0] dig_in;
   logic [OWNER_W*NUM_PINS-1:0] next_owner;

   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         pin_lane #(
            .NUM_REMAP_OUT(NUM_REMAP_OUT)
         ) u_lane (
            .analog_sel(analog_select_reg[g]),
            .direction(direction_reg[g]),
            .latch_val(output_latch_reg[g]),
            .sel(remap_selector[g]),
            .ded_analog(ded_analog_en[g]),
            .ded_out_en(ded_out_en[g]),
            .ded_out_val(ded_out_val[g]),
            .ded_in_en(ded_in_en[g]),
            .remap_out_val(remap_out_val),
            .pin_level(pin_in[g]),
            .is_analog(is_analog[g]),
            .out_val(next_pin_out[g]),
            .oe(next_pin_oe[g]),
            .dig_in(dig_in[g]),
            .owner(next_owner[OWNER_W*g +: OWNER_W])
         );
      end
   endgenerate

   // Remappable inputs read any digital pin, even one owned by a dedicated function
   logic [NUM_REMAP_IN-1:0] next_remap_in;
   generate
      for (g = 0; g < NUM_REMAP_IN; g++) begin : g_rin
         assign next_remap_in[g] = dig_in[remap_input_src[g]]; // see RULE_10
      end
   endgenerate

   // Dedicated input only when dedicated function enabled and pin digital
   logic [NUM_PINS-1:0] next_ded_in;
   logic [NUM_PINS-1:0] next_latch_rd;
   assign next_ded_in = dig_in & ded_in_en;
   assign next_latch_rd = output_latch_reg & ~is_analog; // see RULE_02

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   // Pin drive
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_out <= '0;
         pin_oe <= '0;
      end else if (clk_en) begin
         pin_out <= next_pin_out; // see RULE_13
         pin_oe <= next_pin_oe; // see RULE_13
      end
   end

   // Weak pulls
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_pullup_en <= '0;
         pin_pulldown_en <= '0;
      end else if (clk_en) begin
         pin_pullup_en <= pullup_enable_reg;
         pin_pulldown_en <= pulldown_enable_reg;
      end
   end

   // Pin and latch read-back
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_level_reg <= '0;
         output_latch_rd <= '0;
      end else if (clk_en) begin
         pin_level_reg <= dig_in; // see RULE_02
         output_latch_rd <= next_latch_rd;
      end
   end

   // Analog select read-back and dedicated inputs
   always_ff @(posedge clk) begin
      if (reset) begin
         analog_select_rd <= '0;
         ded_in_val <= '0;
      end else if (clk_en) begin
         analog_select_rd <= analog_select_reg;
         ded_in_val <= next_ded_in;
      end
   end

   // Remappable inputs and pin owner
   always_ff @(posedge clk) begin
      if (reset) begin
         remap_in_val <= '0;
         pin_owner <= '0;
      end else if (clk_en) begin
         remap_in_val <= next_remap_in; // see RULE_12
         pin_owner <= next_owner;
      end
   end
endmodule // pin_function_arbiter

// ---------------------------------------------------------------
// One pin: owner, output source, output enable, input gating
// ---------------------------------------------------------------
module pin_lane #(
   parameter int NUM_REMAP_OUT = pin_function_pkg::NUM_REMAP_OUT
) (
   // Registered configuration of this pin
   input wire logic analog_sel,
   input wire logic direction,
   input wire logic latch_val,
   input wire logic [pin_function_pkg::SEL_W-1:0] sel,
   // Peripheral requests on this pin
   input wire logic ded_analog,
   input wire logic ded_out_en,
   input wire logic ded_out_val,
   input wire logic ded_in_en,
   input wire logic [NUM_REMAP_OUT-1:0] remap_out_val,
   // Pin level
   input wire logic pin_level,
   // Arbitration results
   output logic is_analog,
   output logic out_val,
   output logic oe,
   output logic dig_in,
   output pin_function_pkg::owner_t owner
);
   logic remap_sel_on;
   logic remap_in_range;
   logic remap_bit;
   logic ded_digital;

   assign is_analog = analog_sel | ded_analog;
   assign remap_sel_on = (sel != pin_function_pkg::REMAP_NONE);
   assign ded_digital = ded_out_en | ded_in_en;
   // Selector k (1..N) picks remappable output k-1; see RULE_08
   assign remap_in_range = remap_sel_on && (32'(sel) <= NUM_REMAP_OUT);
   assign remap_bit = remap_in_range ? remap_out_val[32'(sel) - 1] : 1'b0;
   // Single output source, dedicated first, then remap, then port latch
   assign out_val = ded_out_en ? ded_out_val : // see RULE_09
      remap_sel_on ? remap_bit : latch_val; // see RULE_07
   // Port direction still drives while analog; see RULE_04 and RULE_11
   assign oe = ded_out_en | remap_sel_on | ~direction;
   // Digital input buffer gated in analog mode; see RULE_02 and RULE_11
   assign dig_in = is_analog ? pin_function_pkg::GATED_READ : pin_level;
   // Owner by fixed priority; see RULE_05
   assign owner = is_analog ? pin_function_pkg::OWN_ANALOG :
      ded_digital ? pin_function_pkg::OWN_DEDICATED :
      remap_sel_on ? pin_function_pkg::OWN_REMAP : pin_function_pkg::OWN_PORT;
endmodule // pin_lane

//--- design/pin_function_pkg.sv
package pin_function_pkg;
   // ---------------------------------------------------------------
   // Defaults and encodings
   // ---------------------------------------------------------------
   localparam int NUM_PINS = 8;
   localparam int NUM_REMAP_OUT = 4;
   localparam int NUM_REMAP_IN = 4;
   localparam int SEL_W = 3;
   localparam int PIN_IDX_W = 3;
   // Remap selector value meaning "no remappable output on this pin"
   localparam logic [SEL_W-1:0] REMAP_NONE = 3'h0;
   // Reset values of configuration registers, and the value read from a gated input
   localparam logic RST_ANALOG = 1'h1;
   localparam logic RST_DIR_INPUT = 1'h1;
   localparam logic RST_LATCH = 1'h0;
   localparam logic RST_PULL = 1'h0;
   localparam logic GATED_READ = 1'h0;

   // Pin owner, priority highest first
   typedef enum logic [2:0] {
      OWN_ANALOG = 3'h0,
      OWN_DEDICATED = 3'h1,
      OWN_REMAP = 3'h3,
      OWN_PORT = 3'h2
   } owner_t;
endpackage

//--- tb/pin_function_arbiter_asserts.sv
`timescale 1ns/1ps
// ----
// Pin arbiter checks
// ----
module pin_function_arbiter_asserts #(parameter int NUM_PINS = 8) (
   // Clock, reset, inputs
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [NUM_PINS-1:0] ded_analog_en,
   input wire logic [NUM_PINS-1:0] ded_out_en,
   input wire logic [NUM_PINS-1:0] ded_out_val,
   input wire logic [NUM_PINS-1:0] pin_in,
   input wire logic pullup_enable_we,
   input wire logic [NUM_PINS-1:0] pullup_enable_wdata,
   // Outputs
   input wire logic [NUM_PINS-1:0] pin_out,
   input wire logic [NUM_PINS-1:0] pin_oe,
   input wire logic [NUM_PINS-1:0] pin_pullup_en,
   input wire logic [NUM_PINS-1:0] pin_level_reg,
   input wire logic [NUM_PINS-1:0] output_latch_rd,
   input wire logic [NUM_PINS-1:0] analog_select_rd,
   input wire logic [3*NUM_PINS-1:0] pin_owner
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_RESET_ANALOG: assert property ($fell(reset) && clk_en
      |=> pin_owner == '0 && &analog_select_rd)
      else $error("pins not analog after reset");
   AST_GATE_LEVEL: assert property ($stable(analog_select_rd)
      |-> (pin_level_reg & analog_select_rd) == '0)
      else $error("analog pin level read not zero");
   AST_GATE_LATCH: assert property ($stable(analog_select_rd)
      |-> (output_latch_rd & analog_select_rd) == '0)
      else $error("analog pin latch read not zero");
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_own
      AST_OWNER_ANALOG: assert property (clk_en && ded_analog_en[i]
         |=> pin_owner[3*i+:3] == 3'h0)
         else $error("analog function does not own pin");
   end
   AST_DED_OUT: assert property (clk_en
      |=> (pin_oe & $past(ded_out_en)) == $past(ded_out_en)
      && ((pin_out ^ $past(ded_out_val)) & $past(ded_out_en)) == '0)
      else $error("dedicated output not driven");
   AST_LEVEL: assert property (clk_en
      |=> ((pin_level_reg ^ $past(pin_in)) & ~analog_select_rd & ~$past(ded_analog_en)) == '0)
      else $error("digital pin level wrong");
   AST_PULLUP: assert property (clk_en && pullup_enable_we
      ##1 clk_en && !pullup_enable_we |=> pin_pullup_en == $past(pullup_enable_wdata, 2))
      else $error("pull-up enables wrong");
   AST_FREEZE: assert property (!clk_en |=> $stable(pin_oe) && $stable(pin_owner))
      else $error("outputs moved while frozen");
endmodule // pin_function_arbiter_asserts

bind pin_function_arbiter pin_function_arbiter_asserts #(.NUM_PINS(NUM_PINS)) u_chk (.clk(clk),
   .reset(reset), .clk_en(clk_en), .ded_analog_en(ded_analog_en), .ded_out_en(ded_out_en),
   .ded_out_val(ded_out_val), .pin_in(pin_in), .pullup_enable_we(pullup_enable_we),
   .pullup_enable_wdata(pullup_enable_wdata), .pin_out(pin_out), .pin_oe(pin_oe),
   .pin_pullup_en(pin_pullup_en), .pin_level_reg(pin_level_reg),
   .output_latch_rd(output_latch_rd), .analog_select_rd(analog_select_rd), .pin_owner(pin_owner));

//--- tb/board_pins.sv
`timescale 1ns/1ps
// ----
// Board side of the pins
// ----
module board_pins #(parameter int N = 8) (
   // From the device
   input wire logic [N-1:0] pin_out,
   input wire logic [N-1:0] pin_oe,
   input wire logic [N-1:0] pin_pullup_en,
   input wire logic [N-1:0] pin_pulldown_en,
   // Board source and sensed level
   input wire logic [N-1:0] ext_val,
   output logic [N-1:0] pin_in
);
   // Driven pins show the device value, else the pulls, else the board source
   assign pin_in = (pin_oe & pin_out)
      | (~pin_oe & (pin_pullup_en | (~pin_pulldown_en & ext_val)));
endmodule // board_pins

//--- tb/tb_pin_function_arbiter.sv
`timescale 1ns/1ps
// ----
// Testbench
// ----
module tb_pin_function_arbiter;
   logic clk = 0, reset = 1, clk_en = 1, rs_we = 0, ri_we = 0;
   logic [4:0] we = '0;
   logic [7:0] wd [5] = '{default: 8'h00};
   logic [2:0] rs_pin = 3'h0, rs_d = 3'h0, ri_d = 3'h0;
   logic [1:0] ri_f = 2'h0;
   logic [7:0] dan = 8'h00, doe = 8'h00, dval = 8'h00, dien = 8'h00, ext = 8'hFF;
   logic [3:0] rout = 4'h0;
   logic [7:0] pin_in, pin_out, pin_oe, pu, pd, lvl, latrd, anrd, dinv;
   logic [3:0] rinv;
   logic [23:0] owner;
   int n_fail = 0, checks_done = 0;
   always #20 clk = ~clk;
   pin_function_arbiter dut (.clk(clk), .reset(reset), .clk_en(clk_en),
      .analog_select_we(we[0]), .analog_select_wdata(wd[0]), .direction_we(we[1]),
      .direction_wdata(wd[1]), .output_latch_we(we[2]), .output_latch_wdata(wd[2]),
      .pullup_enable_we(we[3]), .pullup_enable_wdata(wd[3]), .pulldown_enable_we(we[4]),
      .pulldown_enable_wdata(wd[4]), .remap_selector_we(rs_we), .remap_selector_pin(rs_pin),
      .remap_selector_wdata(rs_d), .remap_input_we(ri_we), .remap_input_func(ri_f),
      .remap_input_wdata(ri_d), .ded_analog_en(dan), .ded_out_en(doe), .ded_out_val(dval),
      .ded_in_en(dien), .remap_out_val(rout), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_pullup_en(pu), .pin_pulldown_en(pd), .pin_level_reg(lvl),
      .output_latch_rd(latrd), .analog_select_rd(anrd), .ded_in_val(dinv),
      .remap_in_val(rinv), .pin_owner(owner));
   board_pins #(.N(8)) board (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pu),
      .pin_pulldown_en(pd), .ext_val(ext), .pin_in(pin_in));
   task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input int k, input logic [7:0] d);
      @(negedge clk); we[k] = 1'b1; wd[k] = d;
      @(negedge clk); we[k] = 1'b0;
   endtask
   task rsel(input logic [2:0] p, input logic [2:0] v);
      @(negedge clk); rs_we = 1'b1; rs_pin = p; rs_d = v;
      @(negedge clk); rs_we = 1'b0;
   endtask
   task rin(input logic [1:0] f, input logic [2:0] p);
      @(negedge clk); ri_we = 1'b1; ri_f = f; ri_d = p;
      @(negedge clk); ri_we = 1'b0;
   endtask
   task st;
      repeat (3) @(negedge clk);
   endtask
   task results;
      if (n_fail == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task t_reset;
      st;
      chk("analog_select", 24'hFF, anrd);
      chk("owner", 24'h0, owner);
      chk("level", 24'h0, lvl);
   endtask
   task t_digital;
      wr(0, 8'h00); ext = 8'hA5; st;
      chk("level", 24'hA5, lvl);
      chk("owner", {8{3'h2}}, owner);
   endtask
   task t_analog_out;
      wr(0, 8'hFF); wr(2, 8'hAA); wr(1, 8'h00); st;
      chk("oe", 24'hFF, pin_oe);
      chk("out", 24'hAA, pin_out);
      chk("latch_rd", 24'h0, latrd);
      wr(0, 8'h00);
   endtask
   task t_prio;
      rsel(3'h0, 3'h1); rsel(3'h3, 3'h1); rsel(3'h1, 3'h1);
      rout = 4'h1; doe = 8'h02; wr(1, 8'hFB); st;
      chk("oe", 24'hF, pin_oe[3:0]);
      chk("out", 24'h9, pin_out[3:0]);
      chk("owner", {3'h3, 3'h2, 3'h1, 3'h3}, owner[11:0]);
   endtask
   task t_rin;
      dien = 8'h02; rin(2'h0, 3'h1); rin(2'h1, 3'h1); dval = 8'h02; st;
      chk("remap_in", 24'h3, rinv[1:0]);
      chk("ded_in", 24'h1, dinv[1]);
      dan = 8'h02; st;
      chk("remap_in", 24'h0, rinv[1:0]);
      chk("ded_in", 24'h0, dinv[1]);
      chk("oe", 24'h1, pin_oe[1]);
      dan = 8'h00;
   endtask
   task t_pull;
      wr(3, 8'h0F); wr(4, 8'hF0); st;
      chk("pullup", 24'h0F, pu);
      chk("pulldown", 24'hF0, pd);
      clk_en = 1'b0; wr(3, 8'hFF); st;
      chk("pullup", 24'h0F, pu);
      clk_en = 1'b1;
   endtask
   initial begin
      repeat (4) @(negedge clk);
      reset = 1'b0;
      t_reset; t_digital; t_analog_out; t_prio; t_rin; t_pull;
      results;
   end
   initial begin
      #200000;
      n_fail++;
      results;
   end
endmodule // tb_pin_function_arbiter
